// ==== core/alias_guard.sv ====
// Alias conflict tracking and code-write hazard detection for one core.
// Assumes all requests come from logic on clk; a refused request is re-presented.
//
// Notes on behaviour
// - Level-one lines 64 bytes, level-two 128
// - Level-one: 32 sets, 2K alias stride
// - Four ways; fifth alias line evicts
// - Store forwarding compares address modulo 16K
// - Aliased load waits for store data
// - One trace per 16K start alias
// - Level-two: 256 sets, 32K alias stride
// - Eight ways; ninth alias line evicts
// - Same low 16 bits waits for earlier
// - Store near executed code, fetch near write
// - Hazard clears pipeline and trace cache
// - Data written before fetch raises nothing
// - Flushed code refetches, modified bytes win
// - Code-segment data stores count as code writes
// - Indirect trace miss fetches following bytes
`timescale 1ns/1ps
module alias_guard #(
    parameter int AW = alias_pkg::ADDR_W,
    parameter int SQ_DEPTH = alias_pkg::SQ_DEPTH,
    parameter int EXEC_DEPTH = alias_pkg::EXEC_DEPTH,
    parameter int TC_BITS = alias_pkg::TC_ALIAS_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ref_valid,
    input wire logic [AW-1:0] ref_addr,
    input wire logic ref_store,
    input wire logic fill_done,
    input wire logic st_valid,
    input wire logic [AW-1:0] st_addr,
    input wire logic st_code_seg,
    input wire logic st_data_valid,
    input wire logic [$clog2(SQ_DEPTH)-1:0] st_data_idx,
    input wire logic st_retire,
    input wire logic fetch_valid,
    input wire logic [AW-1:0] fetch_addr,
    input wire logic trace_valid,
    input wire logic [AW-1:0] trace_addr,
    input wire logic ind_miss,
    input wire logic [AW-1:0] ind_next_addr,
    input wire logic remote_write_valid,
    input wire logic [AW-1:0] remote_write_addr,
    output logic ref_wait_q,
    output logic fwd_hold_q,
    output logic st_refused_q,
    output logic [$clog2(SQ_DEPTH)-1:0] st_idx_q,
    output logic l1_hit_q,
    output logic l1_miss_q,
    output logic l1_evict_q,
    output logic l2_miss_q,
    output logic l2_evict_q,
    output logic tc_hit_q,
    output logic tc_replace_q,
    output logic code_write_hazard_q,
    output logic pipe_flush_q,
    output logic spec_fetch_q,
    output logic [AW-1:0] spec_fetch_addr_q
);
    localparam int SQW = $clog2(SQ_DEPTH);
    localparam int EW = $clog2(EXEC_DEPTH);
    localparam int TC_ENTRIES = 1 << TC_BITS;

    // Upper bits from lo upward agree
    function automatic logic upper_eq(input logic [AW-1:0] a, input logic [AW-1:0] b,
        input int lo);
        return ((a ^ b) >> lo) == '0;
    endfunction : upper_eq

    // Low bits below hi agree; higher bits are ignored
    function automatic logic low_eq(input logic [AW-1:0] a, input logic [AW-1:0] b,
        input int hi);
        return ((a ^ b) << (AW - hi)) == '0;
    endfunction : low_eq

    dir_if #(.AW(AW)) l1 ();
    dir_if #(.AW(AW)) l2 ();

    cache_dir #(.LINE_BITS(alias_pkg::L1_LINE_BITS), .SETS(alias_pkg::L1_SETS),
        .WAYS(alias_pkg::L1_WAYS), .AW(AW)) u_l1 (.clk(clk), .reset(reset), .port(l1));
    cache_dir #(.LINE_BITS(alias_pkg::L2_LINE_BITS), .SETS(alias_pkg::L2_SETS),
        .WAYS(alias_pkg::L2_WAYS), .AW(AW)) u_l2 (.clk(clk), .reset(reset), .port(l2));

    // Pending store queue
    logic [AW-1:0] sq_addr_q [SQ_DEPTH];
    logic [SQ_DEPTH-1:0] sq_valid_q;
    logic [SQ_DEPTH-1:0] sq_data_q;
    logic [SQW-1:0] sq_head_q;
    logic [SQW-1:0] sq_tail_q;
    logic [SQ_DEPTH-1:0] fwd_match;
    logic [SQ_DEPTH-1:0] fetch_match;

    // Recently executed code addresses
    logic [AW-1:0] exec_addr_q [EXEC_DEPTH];
    logic [EXEC_DEPTH-1:0] exec_valid_q;
    logic [EW-1:0] exec_ptr_q;
    logic [EXEC_DEPTH-1:0] exec_st_match;
    logic [EXEC_DEPTH-1:0] exec_rm_match;

    // In-flight reference tracking
    logic busy_q;
    logic [AW-1:0] busy_addr_q;
    logic pend_q;
    logic [AW-1:0] pend_addr_q;

    // Trace cache start directory
    logic [TC_ENTRIES-1:0] tc_valid_q;
    logic [AW-TC_BITS-1:0] tc_tag_q [TC_ENTRIES];

    for (genvar i = 0; i < SQ_DEPTH; i++) begin : g_sq
        assign fwd_match[i] = sq_valid_q[i] && !sq_data_q[i]
            && low_eq(sq_addr_q[i], ref_addr, alias_pkg::FWD_ALIAS_BITS);
        assign fetch_match[i] = sq_valid_q[i]
            && upper_eq(sq_addr_q[i], fetch_addr, alias_pkg::WRITE_SUB_BITS);
    end
    for (genvar j = 0; j < EXEC_DEPTH; j++) begin : g_exec
        assign exec_st_match[j] = exec_valid_q[j]
            && upper_eq(exec_addr_q[j], st_addr, alias_pkg::EXEC_SUB_BITS);
        assign exec_rm_match[j] = exec_valid_q[j]
            && upper_eq(exec_addr_q[j], remote_write_addr, alias_pkg::PAGE_BITS);
    end

    // Pending stores are all older than the presented load
    wire fwd_block = ref_valid && !ref_store && (|fwd_match);
    wire inflight_block = ref_valid
        && ((busy_q && low_eq(busy_addr_q, ref_addr, alias_pkg::INFLIGHT_BITS))
        || (pend_q && low_eq(pend_addr_q, ref_addr, alias_pkg::INFLIGHT_BITS)));
    wire ref_take = ref_valid && !fwd_block && !inflight_block;

    wire sq_full = &sq_valid_q;
    wire st_take = st_valid && !sq_full;

    // Exec entries exist only once code was fetched, so earlier writes stay quiet
    wire hazard = (st_take && ((|exec_st_match) || st_code_seg))
        || (fetch_valid && (|fetch_match))
        || (remote_write_valid && (|exec_rm_match));

    wire [TC_BITS-1:0] tc_idx = trace_addr[TC_BITS-1:0];
    wire [AW-TC_BITS-1:0] tc_tag = trace_addr[AW-1:TC_BITS];
    wire tc_hit = tc_valid_q[tc_idx] && (tc_tag_q[tc_idx] == tc_tag);
    wire tc_fill = trace_valid && !tc_hit && !hazard;

    wire exec_rec = fetch_valid || ind_miss;
    wire [AW-1:0] exec_rec_addr = fetch_valid ? fetch_addr : ind_next_addr;

    assign l1.req = ref_take;
    assign l1.addr = ref_addr;
    assign l2.req = l1.miss;
    assign l2.addr = pend_addr_q;
    assign l1_hit_q = l1.hit;
    assign l1_miss_q = l1.miss;
    assign l1_evict_q = l1.evict;
    assign l2_miss_q = l2.miss;
    assign l2_evict_q = l2.evict;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_wait_q <= 1'b0;
            fwd_hold_q <= 1'b0;
            pend_q <= 1'b0;
            pend_addr_q <= '0;
            busy_q <= 1'b0;
            busy_addr_q <= '0;
        end else begin
            ref_wait_q <= ref_valid && !ref_take;
            fwd_hold_q <= fwd_block;
            pend_q <= ref_take;
            pend_addr_q <= ref_addr;
            // A new miss wins over a completion in the same cycle
            if (l1.miss) begin
                busy_q <= 1'b1;
                busy_addr_q <= pend_addr_q;
            end else if (fill_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sq_valid_q <= '0;
            sq_data_q <= '0;
            sq_head_q <= '0;
            sq_tail_q <= '0;
            st_refused_q <= 1'b0;
            st_idx_q <= '0;
        end else begin
            st_refused_q <= st_valid && sq_full;
            if (st_data_valid) begin
                sq_data_q[st_data_idx] <= 1'b1;
            end
            if (st_retire && sq_valid_q[sq_head_q]) begin
                sq_valid_q[sq_head_q] <= 1'b0;
                sq_head_q <= sq_head_q + 1'b1;
            end
            if (st_take) begin
                sq_valid_q[sq_tail_q] <= 1'b1;
                sq_data_q[sq_tail_q] <= 1'b0;
                st_idx_q <= sq_tail_q;
                sq_tail_q <= sq_tail_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (st_take) begin
            sq_addr_q[sq_tail_q] <= st_addr;
        end
        if (exec_rec && !hazard) begin
            exec_addr_q[exec_ptr_q] <= exec_rec_addr;
        end
        if (tc_fill) begin
            tc_tag_q[tc_idx] <= tc_tag;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exec_valid_q <= '0;
            exec_ptr_q <= '0;
            tc_valid_q <= '0;
            tc_hit_q <= 1'b0;
            tc_replace_q <= 1'b0;
            code_write_hazard_q <= 1'b0;
            pipe_flush_q <= 1'b0;
            spec_fetch_q <= 1'b0;
            spec_fetch_addr_q <= '0;
        end else begin
            code_write_hazard_q <= hazard;
            pipe_flush_q <= hazard;
            tc_hit_q <= trace_valid && tc_hit && !hazard;
            tc_replace_q <= tc_fill && tc_valid_q[tc_idx];
            spec_fetch_q <= ind_miss;
            if (ind_miss) begin
                spec_fetch_addr_q <= ind_next_addr;
            end
            if (hazard) begin
                // Everything fetched so far is suspect and must be refetched
                exec_valid_q <= '0;
                tc_valid_q <= '0;
            end else begin
                if (exec_rec) begin
                    exec_valid_q[exec_ptr_q] <= 1'b1;
                    exec_ptr_q <= exec_ptr_q + 1'b1;
                end
                if (tc_fill) begin
                    tc_valid_q[tc_idx] <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence load_on_pending;
        ref_valid && !ref_store && (|fwd_match);
    endsequence
    sequence held_then_refused;
        ref_wait_q && fwd_hold_q;
    endsequence

    fwd_hold_load_a: assert property (load_on_pending |=> held_then_refused)
        else $error("aliased load was not held");
    inflight_wait_a: assert property (inflight_block |=> ref_wait_q && !l1.hit && !l1.miss)
        else $error("aliased reference was not refused");
    store_exec_hit_a: assert property (st_take && (|exec_st_match) |=> code_write_hazard_q)
        else $error("store to executed subpage not flagged");
    fetch_pend_hit_a: assert property (fetch_valid && (|fetch_match) |=> pipe_flush_q)
        else $error("fetch near pending store not flagged");
    hazard_flush_a: assert property (code_write_hazard_q |-> pipe_flush_q
        && exec_valid_q == '0 && tc_valid_q == '0)
        else $error("hazard without full flush");
    quiet_write_a: assert property (st_valid && exec_valid_q == '0 && !st_code_seg
        && !fetch_valid && !remote_write_valid |=> !code_write_hazard_q)
        else $error("write to unfetched page flagged");
    code_seg_st_a: assert property (st_take && st_code_seg |=> code_write_hazard_q)
        else $error("code segment store not flagged");
    spec_fetch_a: assert property (ind_miss |=> spec_fetch_q
        && spec_fetch_addr_q == $past(ind_next_addr))
        else $error("speculative fetch address wrong");
    // Checked on the first cycle so that a later flush cannot mask the refill
    tc_alias_a: assert property (trace_valid && !tc_hit && tc_valid_q[tc_idx] && !hazard
        |=> tc_replace_q && tc_valid_q[$past(tc_idx)])
        else $error("aliased trace not replaced");
endmodule : alias_guard

// ==== common/alias_pkg.sv ====
// Shared constants for the memory alias and code-write detection block.
// Assumes linear byte addresses from the core's load, store and fetch logic.
package alias_pkg;
    localparam int ADDR_W = 32;
    localparam int L1_LINE_BITS = 6;
    localparam int L1_SETS = 32;
    localparam int L1_WAYS = 4;
    localparam int L2_LINE_BITS = 7;
    localparam int L2_SETS = 256;
    localparam int L2_WAYS = 8;
    localparam int FWD_ALIAS_BITS = 14;
    localparam int TC_ALIAS_BITS = 14;
    localparam int INFLIGHT_BITS = 16;
    localparam int EXEC_SUB_BITS = 10;
    localparam int WRITE_SUB_BITS = 11;
    localparam int PAGE_BITS = 12;
    localparam int SQ_DEPTH = 4;
    localparam int EXEC_DEPTH = 8;
endpackage : alias_pkg

// ==== common/dir_if.sv ====
// Lookup channel between the alias block and one cache directory.
// Answers arrive one clock after the request, from directory flip-flops.
`timescale 1ns/1ps
interface dir_if #(parameter int AW = alias_pkg::ADDR_W);
    logic req;
    logic [AW-1:0] addr;
    logic hit;
    logic miss;
    logic evict;
    logic [AW-1:0] evict_addr;
    modport client (output req, output addr, input hit, input miss, input evict,
        input evict_addr);
    modport dir (input req, input addr, output hit, output miss, output evict,
        output evict_addr);
endinterface : dir_if

// ==== core/cache_dir.sv ====
// Set-associative tag directory with round-robin victim choice per set.
// Assumes one lookup per clock; a miss allocates the line immediately.
`timescale 1ns/1ps
module cache_dir #(
    parameter int LINE_BITS = alias_pkg::L1_LINE_BITS,
    parameter int SETS = alias_pkg::L1_SETS,
    parameter int WAYS = alias_pkg::L1_WAYS,
    parameter int AW = alias_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic reset,
    dir_if.dir port
);
    localparam int SB = $clog2(SETS);
    localparam int WB = $clog2(WAYS);
    localparam int TW = AW - LINE_BITS - SB;

    logic [TW-1:0] tag_q [SETS][WAYS];
    logic [WAYS-1:0] valid_q [SETS];
    logic [WB-1:0] victim_q [SETS];
    logic [WAYS-1:0] way_hit;

    // Offset bits inside the line never take part in the compare
    wire [SB-1:0] set_idx = port.addr[LINE_BITS +: SB];
    wire [TW-1:0] tag_in = port.addr[AW-1 -: TW];
    wire [WB-1:0] victim = victim_q[set_idx];
    wire victim_used = valid_q[set_idx][victim];

    for (genvar w = 0; w < WAYS; w++) begin : g_way
        assign way_hit[w] = valid_q[set_idx][w] && (tag_q[set_idx][w] == tag_in);
    end
    wire any_hit = |way_hit;
    wire alloc = port.req && !any_hit;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port.hit <= 1'b0;
            port.miss <= 1'b0;
            port.evict <= 1'b0;
            port.evict_addr <= '0;
            for (int s = 0; s < SETS; s++) begin
                valid_q[s] <= '0;
                victim_q[s] <= '0;
            end
        end else begin
            port.hit <= port.req && any_hit;
            port.miss <= alloc;
            port.evict <= alloc && victim_used;
            port.evict_addr <= {tag_q[set_idx][victim], set_idx, {LINE_BITS{1'b0}}};
            if (alloc) begin
                valid_q[set_idx][victim] <= 1'b1;
                victim_q[set_idx] <= victim + 1'b1;
            end
        end
    end

    // Tags carry no reset; valid bits guard them
    always_ff @(posedge clk) begin
        if (alloc) begin
            tag_q[set_idx][victim] <= tag_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    evict_needs_miss_a: assert property (port.evict |-> port.miss)
        else $error("eviction reported without a miss");
    full_set_evicts_a: assert property (alloc && victim_used |=> port.evict)
        else $error("full set allocated without eviction");
    hit_miss_excl_a: assert property (!(port.hit && port.miss))
        else $error("hit and miss reported together");
endmodule : cache_dir

// ==== bench/core_ref_model.sv ====
// Model of the core's load/store unit on the reference port of the alias block.
// Assumes answers one clock after a taken request and level two one clock later.
`timescale 1ns/1ps
module core_ref_model #(parameter int AW = 32) (
    input wire logic clk,
    input wire logic ref_wait_q,
    input wire logic fwd_hold_q,
    input wire logic l1_hit_q,
    input wire logic l1_miss_q,
    input wire logic l1_evict_q,
    input wire logic l2_miss_q,
    input wire logic l2_evict_q,
    output logic ref_valid,
    output logic [AW-1:0] ref_addr,
    output logic ref_store,
    output logic fill_done
);
    logic r_wait, r_hold, r_hit, r_miss, r_evict, r_l2m, r_l2e;

    initial begin
        ref_valid = 1'b0;
        ref_addr = '0;
        ref_store = 1'b0;
        fill_done = 1'b0;
    end

    // A released address bus shows the inverse so a stale value never matches by luck
    task automatic issue(input logic [AW-1:0] a, input logic st, input int tries = 4,
        input bit fill = 1'b1);
        int n;
        bit got;
        n = 0;
        got = 1'b0;
        {r_wait, r_hold, r_hit, r_miss, r_evict, r_l2m, r_l2e} = 'x;
        while (!got && n < tries) begin
            @(posedge clk);
            ref_valid <= 1'b1;
            ref_addr <= a;
            ref_store <= st;
            @(posedge clk);
            ref_valid <= 1'b0;
            ref_addr <= ~a;
            ref_store <= ~st;
            #1;
            if (n == 0) begin
                r_wait = ref_wait_q;
                r_hold = fwd_hold_q;
            end
            got = (ref_wait_q !== 1'b1);
            r_hit = l1_hit_q;
            r_miss = l1_miss_q;
            r_evict = l1_evict_q;
            n++;
        end
        if (got) begin
            @(posedge clk);
            #1;
            r_l2m = l2_miss_q;
            r_l2e = l2_evict_q;
            if (fill && r_miss === 1'b1) begin
                do_fill(0);
            end
        end
    endtask : issue

    // Line fill completes after gap idle clocks, so slow memory can be modelled
    task automatic do_fill(input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        fill_done <= 1'b1;
        @(posedge clk);
        fill_done <= 1'b0;
    endtask : do_fill
endmodule : core_ref_model

// ==== bench/cache_alias_and_code_write_detect_tb.sv ====
// Self-checking bench for alias_guard.
// Assumes core_ref_model drives the reference port; the bench drives all other inputs.
`timescale 1ns/1ps
module cache_alias_and_code_write_detect_tb;
    localparam int AW = alias_pkg::ADDR_W;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ref_valid, ref_store, fill_done, ref_wait_q, fwd_hold_q, st_refused_q;
    logic [AW-1:0] ref_addr, spec_fetch_addr_q;
    logic st_valid = 0, st_code_seg = 0, st_data_valid = 0, st_retire = 0;
    logic fetch_valid = 0, trace_valid = 0, ind_miss = 0, remote_write_valid = 0;
    logic [AW-1:0] st_addr = '0, fetch_addr = '0, trace_addr = '0;
    logic [AW-1:0] ind_next_addr = '0, remote_write_addr = '0;
    logic [1:0] st_data_idx = '0, st_idx_q;
    logic l1_hit_q, l1_miss_q, l1_evict_q, l2_miss_q, l2_evict_q, tc_hit_q, tc_replace_q;
    logic code_write_hazard_q, pipe_flush_q, spec_fetch_q;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    alias_guard i_dut (.clk(clk), .reset(reset), .ref_valid(ref_valid), .ref_addr(ref_addr),
        .ref_store(ref_store), .fill_done(fill_done), .st_valid(st_valid), .st_addr(st_addr),
        .st_code_seg(st_code_seg), .st_data_valid(st_data_valid), .st_data_idx(st_data_idx),
        .st_retire(st_retire), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .trace_valid(trace_valid), .trace_addr(trace_addr), .ind_miss(ind_miss),
        .ind_next_addr(ind_next_addr), .remote_write_valid(remote_write_valid),
        .remote_write_addr(remote_write_addr), .ref_wait_q(ref_wait_q),
        .fwd_hold_q(fwd_hold_q), .st_refused_q(st_refused_q), .st_idx_q(st_idx_q),
        .l1_hit_q(l1_hit_q), .l1_miss_q(l1_miss_q), .l1_evict_q(l1_evict_q),
        .l2_miss_q(l2_miss_q), .l2_evict_q(l2_evict_q), .tc_hit_q(tc_hit_q),
        .tc_replace_q(tc_replace_q), .code_write_hazard_q(code_write_hazard_q),
        .pipe_flush_q(pipe_flush_q), .spec_fetch_q(spec_fetch_q),
        .spec_fetch_addr_q(spec_fetch_addr_q));

    core_ref_model #(.AW(AW)) i_core (.clk(clk), .ref_wait_q(ref_wait_q),
        .fwd_hold_q(fwd_hold_q), .l1_hit_q(l1_hit_q), .l1_miss_q(l1_miss_q),
        .l1_evict_q(l1_evict_q), .l2_miss_q(l2_miss_q), .l2_evict_q(l2_evict_q),
        .ref_valid(ref_valid), .ref_addr(ref_addr), .ref_store(ref_store),
        .fill_done(fill_done));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic store(input logic [AW-1:0] a, input logic cs, input logic hz);
        @(posedge clk);
        st_valid <= 1'b1;
        st_addr <= a;
        st_code_seg <= cs;
        @(posedge clk);
        st_valid <= 1'b0;
        st_code_seg <= 1'b0;
        #1;
        check("store hazard", code_write_hazard_q, hz);
        check("store flush", pipe_flush_q, hz);
    endtask : store

    // Pulse on one of the single-cycle request inputs, answer checked one clock later
    task automatic fetch(input logic [AW-1:0] a, input logic hz, input bit remote = 0);
        @(posedge clk);
        if (remote) begin
            remote_write_valid <= 1'b1;
            remote_write_addr <= a;
        end else begin
            fetch_valid <= 1'b1;
            fetch_addr <= a;
        end
        @(posedge clk);
        remote_write_valid <= 1'b0;
        fetch_valid <= 1'b0;
        #1;
        check("fetch hazard", code_write_hazard_q, hz);
        check("fetch flush", pipe_flush_q, hz);
    endtask : fetch

    task automatic pulse_retire();
        @(posedge clk);
        st_retire <= 1'b1;
        @(posedge clk);
        st_retire <= 1'b0;
    endtask : pulse_retire

    task automatic trace(input logic [AW-1:0] a, input logic h, input logic r);
        @(posedge clk);
        trace_valid <= 1'b1;
        trace_addr <= a;
        @(posedge clk);
        trace_valid <= 1'b0;
        #1;
        check("tc_hit", tc_hit_q, h);
        check("tc_replace", tc_replace_q, r);
    endtask : trace

    task automatic l1_sets();
        i_core.issue(32'h0000_1000, 1'b0);
        i_core.issue(32'h0000_103F, 1'b0);
        check("same line hit", i_core.r_hit, 1'b1);
        i_core.issue(32'h0000_1040, 1'b0);
        check("next line miss", i_core.r_miss, 1'b1);
        for (int k = 1; k < 5; k++) begin
            i_core.issue(32'h0000_1000 + k * 32'h800, 1'b0);
            check("l1 miss", i_core.r_miss, 1'b1);
            check("l1 evict", i_core.r_evict, k == 4);
        end
        i_core.issue(32'h0000_1000, 1'b0);
        check("evicted line", i_core.r_miss, 1'b1);
    endtask : l1_sets

    task automatic l2_sets();
        for (int k = 0; k < 9; k++) begin
            i_core.issue(32'h0010_0480 + k * 32'h8000, 1'b1);
            check("l2 miss", i_core.r_l2m, 1'b1);
            check("l2 evict", i_core.r_l2e, k == 8);
        end
    endtask : l2_sets

    task automatic inflight_alias();
        i_core.issue(32'h0020_0100, 1'b0, 4, 1'b0);
        i_core.issue(32'h0021_0100, 1'b0, 1);
        check("64K wait", i_core.r_wait, 1'b1);
        i_core.do_fill(3);
        i_core.issue(32'h0021_0100, 1'b0);
        check("64K after fill", i_core.r_wait, 1'b0);
    endtask : inflight_alias

    task automatic fwd_alias();
        store(32'h0030_0200, 1'b0, 1'b0);
        i_core.issue(32'h0030_4200, 1'b0, 1);
        check("16K hold", i_core.r_hold, 1'b1);
        check("16K wait", i_core.r_wait, 1'b1);
        i_core.issue(32'h0030_0240, 1'b0);
        check("other load", i_core.r_wait, 1'b0);
        @(posedge clk);
        st_data_valid <= 1'b1;
        st_data_idx <= st_idx_q;
        @(posedge clk);
        st_data_valid <= 1'b0;
        i_core.issue(32'h0030_4200, 1'b0, 1);
        check("data ready", i_core.r_wait, 1'b0);
        pulse_retire();
        fetch(32'h0030_0200, 1'b0);
    endtask : fwd_alias

    task automatic code_writes();
        fetch(32'h0040_0000, 1'b0);
        store(32'h0040_03F0, 1'b0, 1'b1);
        pulse_retire();
        store(32'h0040_0000, 1'b0, 1'b0);
        pulse_retire();
        trace(32'h0080_0040, 1'b0, 1'b0);
        fetch(32'h0040_0800, 1'b0);
        store(32'h0040_0C00, 1'b0, 1'b0);
        fetch(32'h0040_0FC0, 1'b1);
        pulse_retire();
        store(32'h0050_0000, 1'b1, 1'b1);
        pulse_retire();
        fetch(32'h0060_0000, 1'b0);
        fetch(32'h0060_0F00, 1'b1, 1);
        fetch(32'h0061_0000, 1'b0, 1);
    endtask : code_writes

    task automatic traces();
        trace(32'h0080_0040, 1'b0, 1'b0);
        trace(32'h0080_0040, 1'b1, 1'b0);
        trace(32'h0080_4040, 1'b0, 1'b1);
        trace(32'h0080_0040, 1'b0, 1'b1);
    endtask : traces

    // Four stores fill the queue; a fifth is turned away and leaves the slot index alone
    task automatic queue_full();
        logic [1:0] first;
        logic [1:0] last;
        logic [1:0] want;
        first = '0;
        last = '0;
        for (int k = 0; k < 5; k++) begin
            store(32'h0090_0000 + k * 32'h40, 1'b0, 1'b0);
            check("store refused", st_refused_q, k == 4);
            if (k == 0) begin
                first = st_idx_q;
            end
            if (k == 3) begin
                last = st_idx_q;
            end
        end
        want = first + 2'h3;
        check("slot order", last, want);
        check("refused slot", st_idx_q, last);
        repeat (4) pulse_retire();
        store(32'h0090_0100, 1'b0, 1'b0);
        check("store after retire", st_refused_q, 1'b0);
        pulse_retire();
    endtask : queue_full

    task automatic indirect_miss();
        @(posedge clk);
        ind_miss <= 1'b1;
        ind_next_addr <= 32'h0070_0123;
        @(posedge clk);
        ind_miss <= 1'b0;
        ind_next_addr <= 32'h0000_0000;
        #1;
        check("spec fetch", spec_fetch_q, 1'b1);
        check("spec addr", spec_fetch_addr_q, 32'h0070_0123);
    endtask : indirect_miss

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        l1_sets();
        l2_sets();
        inflight_alias();
        fwd_alias();
        traces();
        code_writes();
        indirect_miss();
        queue_full();
        report_and_stop();
    end

    // Whole run takes well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : cache_alias_and_code_write_detect_tb
